// ==== include/rtc_defs.svh ====
// Register offsets, field positions, reset values and counts of the time counter.
`ifndef RTC_DEFS_SVH
`define RTC_DEFS_SVH
`define ADDR_W 8
`define OFF_SEC 8'h00
`define OFF_MIN 8'h04
`define OFF_HOUR 8'h08
`define OFF_WDAY 8'h0C
`define OFF_DAY 8'h10
`define OFF_MON 8'h14
`define OFF_YEAR 8'h18
`define OFF_CTRL 8'h1C
`define OFF_STAT 8'h20
`define OFF_ALARM 8'h24
`define OFF_IRQ_ST 8'h28
`define OFF_IRQ_MASK 8'h2C
`define CTRL_UNLOCK 0
`define CTRL_RUN 1
`define CTRL_OE 2
`define CTRL_SEL 3
`define CTRL_ALM 4
`define CTRL_CAL_LSB 8
`define CTRL_MASK 32'h0000_FF1F
`define IRQ_SEC 0
`define IRQ_ALM 1
`define IRQ_REF 2
`define IRQ_W 3
`define MASK_SEC 8'h7F
`define MASK_MIN 8'h7F
`define MASK_HOUR 8'h3F
`define MASK_WDAY 8'h07
`define MASK_DAY 8'h3F
`define MASK_MON 8'h1F
`define MASK_ALARM 32'h003F_7F7F
`define RST_WDAY 8'h06
`define RST_DAY 8'h01
`define RST_MON 8'h01
`define RST_YEAR 8'h00
`define RST_CTRL 32'h0000_0002
`define FIRST_ZERO 8'h00
`define FIRST_ONE 8'h01
`define LAST_SEC 8'h59
`define LAST_MIN 8'h59
`define LAST_HOUR 8'h23
`define LAST_WDAY 8'h06
`define LAST_MON 8'h12
`define LAST_YEAR 8'h99
`define MON_FEB 8'h02
`define MON_APR 8'h04
`define MON_JUN 8'h06
`define MON_SEP 8'h09
`define MON_NOV 8'h11
`define DAYS_28 8'h28
`define DAYS_29 8'h29
`define DAYS_30 8'h30
`define DAYS_31 8'h31
`define BCD_NINE 4'h9
`define XTAL_HZ 32768
`define DIV_W 16
`define SEC_LAST 16'h7FFF
`define HALF_TICKS 16'h4000
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// ==== include/rtc_pkg.sv ====
// Types shared by the time and calendar counter.
`include "rtc_defs.svh"
package rtc_pkg;
	typedef struct packed {
		logic awvalid;
		logic [`ADDR_W-1:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [`ADDR_W-1:0] araddr;
		logic rready;
	} axil_req_t;
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} axil_rsp_t;
	typedef struct packed {
		logic [7:0] sec;
		logic [7:0] min;
		logic [7:0] hour;
		logic [7:0] wday;
		logic [7:0] day;
		logic [7:0] mon;
		logic [7:0] year;
	} time_t;
	typedef struct packed {
		axil_rsp_t rsp;
		logic aw_held;
		logic [`ADDR_W-1:0] aw_addr;
		logic w_held;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		time_t tm;
		logic [`DIV_W-1:0] div;
		logic xtal_prev;
		logic cal_pending;
		logic [31:0] ctrl;
		logic [31:0] alarm;
		logic [`IRQ_W-1:0] irq_st;
		logic [`IRQ_W-1:0] irq_mask;
		logic alarm_on;
		logic pin;
		logic pin_oe;
		logic irq;
	} state_t;
endpackage

// ==== design/calendar_timekeeper.sv ====
// BCD time of day and calendar counter with alarm, calibration and AXI4-Lite registers.
//
// Contract
// - Hours count in a 24-hour scheme from 00 to 23 with no AM/PM flag.
// - The counter spans 2000-01-01 00:00:00 to 2099-12-31 23:59:59 with a two-digit year.
// - Leap years are found automatically and give February 29 days, other years 28.
// - Time fields advance once a second and software can see which half second runs.
// - Weekday, day, month and year advance together with the time of day.
// - The hour register holds tens 0-2 in bits 5-4, ones 0-9 in bits 3-0, top bits zero.
// - The minute register holds tens 0-5 in bits 6-4, ones in bits 3-0, bit 7 zero.
// - The second register holds tens 0-5 in bits 6-4 and ones 0-9 in bits 3-0.
// - A write to the hour register takes effect only while the write-unlock bit is one.
// - An alarm is configurable and the pin shows an alarm pulse or a seconds clock.
// - A software calibration adjusts timekeeping by up to about 2.8 s a month either way.
// - The one-second base is counted from the external 32.768 kHz crystal clock.
//
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_defs.svh"
module calendar_timekeeper #(
	parameter int XTAL_HZ = `XTAL_HZ
) (
	// Clock, reset and clock enable.
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	// Register bus.
	input wire rtc_pkg::axil_req_t axil_req,
	output var rtc_pkg::axil_rsp_t axil_rsp,
	// Crystal clock sampled as a level.
	input wire logic xtal_in,
	// Alarm or seconds clock pin.
	output logic pin_out,
	output logic pin_oe,
	// Interrupt.
	output logic irq
);
	localparam logic [`DIV_W-1:0] SEC_LAST = `DIV_W'(XTAL_HZ - 1);
	localparam logic [`DIV_W-1:0] HALF_TICKS = `DIV_W'(XTAL_HZ / 2);

	function automatic rtc_pkg::state_t reset_state();
		rtc_pkg::state_t r;
		r = '0;
		r.rsp.awready = 1'b1;
		r.rsp.wready = 1'b1;
		r.rsp.arready = 1'b1;
		r.tm.wday = `RST_WDAY;
		r.tm.day = `RST_DAY;
		r.tm.mon = `RST_MON;
		r.tm.year = `RST_YEAR;
		r.ctrl = `RST_CTRL;
		return r;
	endfunction

	localparam rtc_pkg::state_t RESET_STATE = reset_state();

	function automatic logic [7:0] bcd_next(input logic [7:0] v,
		input logic [7:0] last, input logic [7:0] first);
		if (v == last) begin
			return first;
		end
		if (v[3:0] == `BCD_NINE) begin
			return {v[7:4] + 4'h1, 4'h0};
		end
		return v + 8'h01;
	endfunction

	function automatic logic is_leap(input logic [7:0] y);
		logic [1:0] rem;
		rem = 2'({y[4], 1'b0} + {1'b0, y[1:0]});
		return rem == 2'h0;
	endfunction

	function automatic logic [7:0] last_day(input logic [7:0] mon,
		input logic [7:0] year);
		logic [7:0] d;
		d = `DAYS_31;
		if (mon == `MON_FEB) begin
			d = is_leap(year) ? `DAYS_29 : `DAYS_28;
		end else if (mon == `MON_APR || mon == `MON_JUN ||
			mon == `MON_SEP || mon == `MON_NOV) begin
			d = `DAYS_30;
		end
		return d;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [`ADDR_W-1:0] word_addr(
		input logic [`ADDR_W-1:0] a);
		return {a[`ADDR_W-1:2], 2'b00};
	endfunction

	rtc_pkg::state_t s_q;
	rtc_pkg::state_t s_d;

	always_comb begin
		logic xtal_rise;
		logic sec_tick;
		logic wrap_s;
		logic wrap_m;
		logic wrap_h;
		logic wrap_d;
		logic wrap_mo;
		logic alarm_hit;
		logic refused;
		logic [`IRQ_W-1:0] ev;
		logic [`IRQ_W-1:0] clr;
		logic [`DIV_W-1:0] term;
		logic [7:0] cal;
		logic [31:0] wd;
		logic [31:0] rd;
		logic wr_ok;
		logic rd_ok;
		s_d = s_q;
		xtal_rise = 1'b0;
		wrap_s = 1'b0;
		wrap_m = 1'b0;
		wrap_h = 1'b0;
		wrap_d = 1'b0;
		wrap_mo = 1'b0;
		alarm_hit = 1'b0;
		ev = '0;
		term = '0;
		sec_tick = 1'b0;
		refused = 1'b0;
		clr = '0;
		wd = '0;
		rd = '0;
		wr_ok = 1'b1;
		rd_ok = 1'b1;
		cal = s_q.ctrl[`CTRL_CAL_LSB +: 8];
		s_d.xtal_prev = xtal_in;
		xtal_rise = xtal_in & ~s_q.xtal_prev;
		// Once an hour one second is lengthened or shortened by cal ticks.
		term = SEC_LAST;
		if (s_q.cal_pending) begin
			term = SEC_LAST - {{(`DIV_W-8){cal[7]}}, cal};
		end
		if (s_q.ctrl[`CTRL_RUN] && xtal_rise) begin
			if (s_q.div >= term) begin
				s_d.div = '0;
				sec_tick = 1'b1;
			end else begin
				s_d.div = s_q.div + `DIV_W'(1);
			end
		end
		wrap_s = s_q.tm.sec == `LAST_SEC;
		wrap_m = wrap_s && s_q.tm.min == `LAST_MIN;
		wrap_h = wrap_m && s_q.tm.hour == `LAST_HOUR;
		wrap_d = wrap_h && s_q.tm.day == last_day(s_q.tm.mon, s_q.tm.year);
		wrap_mo = wrap_d && s_q.tm.mon == `LAST_MON;
		if (sec_tick) begin
			s_d.cal_pending = wrap_m;
			s_d.tm.sec = bcd_next(s_q.tm.sec, `LAST_SEC, `FIRST_ZERO);
			if (wrap_s) begin
				s_d.tm.min = bcd_next(s_q.tm.min, `LAST_MIN, `FIRST_ZERO);
			end
			if (wrap_m) begin
				s_d.tm.hour = bcd_next(s_q.tm.hour, `LAST_HOUR, `FIRST_ZERO);
			end
			if (wrap_h) begin
				s_d.tm.wday = bcd_next(s_q.tm.wday, `LAST_WDAY, `FIRST_ZERO);
				s_d.tm.day = bcd_next(s_q.tm.day,
					last_day(s_q.tm.mon, s_q.tm.year), `FIRST_ONE);
			end
			if (wrap_d) begin
				s_d.tm.mon = bcd_next(s_q.tm.mon, `LAST_MON, `FIRST_ONE);
			end
			if (wrap_mo) begin
				s_d.tm.year = bcd_next(s_q.tm.year, `LAST_YEAR, `FIRST_ZERO);
			end
		end
		// Alarm compares the new time in hour, minute and second.
		alarm_hit = sec_tick && s_q.ctrl[`CTRL_ALM] &&
			{8'h00, s_d.tm.hour, s_d.tm.min, s_d.tm.sec} ==
			(s_q.alarm & `MASK_ALARM);
		if (sec_tick) begin
			s_d.alarm_on = alarm_hit;
		end
		s_d.pin = s_q.ctrl[`CTRL_SEL] ? (s_q.div < HALF_TICKS) :
			s_q.alarm_on;
		s_d.pin_oe = s_q.ctrl[`CTRL_OE];
		// Write address and data are taken in either order.
		if (axil_req.awvalid && s_q.rsp.awready) begin
			s_d.aw_held = 1'b1;
			s_d.aw_addr = axil_req.awaddr;
			s_d.rsp.awready = 1'b0;
		end
		if (axil_req.wvalid && s_q.rsp.wready) begin
			s_d.w_held = 1'b1;
			s_d.w_data = axil_req.wdata;
			s_d.w_strb = axil_req.wstrb;
			s_d.rsp.wready = 1'b0;
		end
		if (s_q.aw_held && s_q.w_held && !s_q.rsp.bvalid) begin
			s_d.aw_held = 1'b0;
			s_d.w_held = 1'b0;
			s_d.rsp.bvalid = 1'b1;
			wd = merge(32'h0, s_q.w_data, s_q.w_strb);
			unique case (word_addr(s_q.aw_addr))
				`OFF_SEC, `OFF_MIN, `OFF_HOUR, `OFF_WDAY,
				`OFF_DAY, `OFF_MON, `OFF_YEAR: begin
					if (!s_q.ctrl[`CTRL_UNLOCK]) begin
						refused = 1'b1;
					end else if (s_q.w_strb[0]) begin
						unique case (word_addr(s_q.aw_addr))
							`OFF_SEC: begin
								s_d.tm.sec = wd[7:0] & `MASK_SEC;
								s_d.div = '0;
							end
							`OFF_MIN: begin
								s_d.tm.min = wd[7:0] & `MASK_MIN;
							end
							`OFF_HOUR: begin
								s_d.tm.hour = wd[7:0] & `MASK_HOUR;
							end
							`OFF_WDAY: begin
								s_d.tm.wday = wd[7:0] & `MASK_WDAY;
							end
							`OFF_DAY: begin
								s_d.tm.day = wd[7:0] & `MASK_DAY;
							end
							`OFF_MON: begin
								s_d.tm.mon = wd[7:0] & `MASK_MON;
							end
							default: begin
								s_d.tm.year = wd[7:0];
							end
						endcase
					end
				end
				`OFF_CTRL: begin
					s_d.ctrl = merge(s_q.ctrl, s_q.w_data, s_q.w_strb) &
						`CTRL_MASK;
				end
				`OFF_ALARM: begin
					s_d.alarm = merge(s_q.alarm, s_q.w_data, s_q.w_strb) &
						`MASK_ALARM;
				end
				`OFF_IRQ_ST: begin
					clr = wd[`IRQ_W-1:0];
				end
				`OFF_IRQ_MASK: begin
					s_d.irq_mask = wd[`IRQ_W-1:0];
				end
				`OFF_STAT: begin
				end
				default: begin
					wr_ok = 1'b0;
				end
			endcase
			s_d.rsp.bresp = wr_ok ? `RESP_OKAY : `RESP_SLVERR;
		end
		if (s_q.rsp.bvalid && axil_req.bready) begin
			s_d.rsp.bvalid = 1'b0;
			s_d.rsp.awready = 1'b1;
			s_d.rsp.wready = 1'b1;
		end
		// Reads answer from the state of the cycle the address is taken.
		if (axil_req.arvalid && s_q.rsp.arready) begin
			unique case (word_addr(axil_req.araddr))
				`OFF_SEC: rd = {24'h0, s_q.tm.sec};
				`OFF_MIN: rd = {24'h0, s_q.tm.min};
				`OFF_HOUR: rd = {24'h0, s_q.tm.hour};
				`OFF_WDAY: rd = {24'h0, s_q.tm.wday};
				`OFF_DAY: rd = {24'h0, s_q.tm.day};
				`OFF_MON: rd = {24'h0, s_q.tm.mon};
				`OFF_YEAR: rd = {24'h0, s_q.tm.year};
				`OFF_CTRL: rd = s_q.ctrl;
				`OFF_STAT: rd = {31'h0, s_q.div >= HALF_TICKS};
				`OFF_ALARM: rd = s_q.alarm;
				`OFF_IRQ_ST: rd = {{(32-`IRQ_W){1'b0}}, s_q.irq_st};
				`OFF_IRQ_MASK: rd = {{(32-`IRQ_W){1'b0}}, s_q.irq_mask};
				default: rd_ok = 1'b0;
			endcase
			s_d.rsp.arready = 1'b0;
			s_d.rsp.rvalid = 1'b1;
			s_d.rsp.rdata = rd;
			s_d.rsp.rresp = rd_ok ? `RESP_OKAY : `RESP_SLVERR;
		end
		if (s_q.rsp.rvalid && axil_req.rready) begin
			s_d.rsp.rvalid = 1'b0;
			s_d.rsp.arready = 1'b1;
		end
		// A new event wins over a clear in the same cycle.
		ev = '0;
		ev[`IRQ_SEC] = sec_tick;
		ev[`IRQ_ALM] = alarm_hit;
		ev[`IRQ_REF] = refused;
		s_d.irq_st = (s_q.irq_st & ~clr) | ev;
		s_d.irq = |(s_d.irq_st & s_d.irq_mask);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= RESET_STATE;
		end else if (clk_en) begin
			s_q <= s_d;
		end
	end

	assign axil_rsp = s_q.rsp;
	assign pin_out = s_q.pin;
	assign pin_oe = s_q.pin_oe;
	assign irq = s_q.irq;
endmodule
`default_nettype wire

// ==== verification/calendar_timekeeper_chk.sv ====
// Bus handshake and clock enable assertions for the time counter.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_defs.svh"
module calendar_timekeeper_chk #(
	parameter int XTAL_HZ = 8
) (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	// Register bus.
	input wire rtc_pkg::axil_req_t axil_req,
	input wire rtc_pkg::axil_rsp_t axil_rsp,
	// Pins.
	input wire logic xtal_in,
	input wire logic pin_out,
	input wire logic pin_oe,
	input wire logic irq
);
	wire rtc_pkg::axil_req_t q = axil_req;
	wire rtc_pkg::axil_rsp_t s = axil_rsp;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	property p_rlat;
		clk_en && q.arvalid && s.arready |=> s.rvalid && !s.arready;
	endproperty
	property p_awtake;
		clk_en && q.awvalid && s.awready |=> !s.awready;
	endproperty
	property p_wlat;
		clk_en && q.awvalid && s.awready && q.wvalid && s.wready
			|=> !s.bvalid ##1 s.bvalid;
	endproperty
	property p_bdone;
		clk_en && s.bvalid && q.bready |=> !s.bvalid && s.awready && s.wready;
	endproperty
	property p_rdone;
		clk_en && s.rvalid && q.rready |=> !s.rvalid && s.arready;
	endproperty
	property p_freeze;
		!clk_en |=> $stable(axil_rsp) && $stable(irq) && $stable(pin_out);
	endproperty
	property p_nowr;
		s.bvalid |-> !s.awready && !s.wready;
	endproperty
	property p_rone;
		s.rvalid |-> !s.arready;
	endproperty
	a_rlat: assert property (p_rlat) else $error("read answer late");
	a_awtake: assert property (p_awtake) else $error("awready held");
	a_wlat: assert property (p_wlat) else $error("write answer off");
	a_bdone: assert property (p_bdone) else $error("write not closed");
	a_rdone: assert property (p_rdone) else $error("read not closed");
	a_freeze: assert property (p_freeze) else $error("moved when idle");
	a_nowr: assert property (p_nowr) else $error("second write taken");
	a_rone: assert property (p_rone) else $error("second read taken");
	c_err: cover property (s.rvalid && s.rresp == `RESP_SLVERR);
	c_irq: cover property ($rose(irq));
	c_pin: cover property (pin_oe && $fell(pin_out));
endmodule
bind calendar_timekeeper calendar_timekeeper_chk #(.XTAL_HZ(XTAL_HZ)) u_chk (
	.aclk(aclk),
	.aresetn(aresetn),
	.clk_en(clk_en),
	.axil_req(axil_req),
	.axil_rsp(axil_rsp),
	.xtal_in(xtal_in),
	.pin_out(pin_out),
	.pin_oe(pin_oe),
	.irq(irq)
);
`default_nettype wire

// ==== verification/calendar_timekeeper_tb.sv ====
// Self-checking bench for the time and calendar counter.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_defs.svh"
module calendar_timekeeper_tb;
	logic aclk, aresetn, clk_en, xtal_in, pin_out, pin_oe, irq;
	rtc_pkg::axil_req_t q;
	rtc_pkg::axil_rsp_t s;
	int fails, checks, y, mo, d, wd, h, mi, se;
	int yt[5] = '{0, 1, 99, 0, 0};
	int mt[5] = '{2, 2, 12, 4, 0};
	int dt[5] = '{28, 28, 31, 30, 0};
	int wt[5] = '{1, 3, 4, 0, 0};
	logic [31:0] rv, ex[7];
	logic [31:0] re[8] = '{0, 0, 0, 32'h6, 32'h1, 32'h1, 0, `RST_CTRL};
	logic [1:0] rr;
	logic [7:0] ra[8] = '{`OFF_SEC, `OFF_MIN, `OFF_HOUR, `OFF_WDAY,
		`OFF_DAY, `OFF_MON, `OFF_YEAR, `OFF_CTRL};
	localparam int HZ = 8;
	calendar_timekeeper #(.XTAL_HZ(HZ)) dut (.aclk(aclk), .aresetn(aresetn),
		.clk_en(clk_en), .axil_req(q), .axil_rsp(s), .xtal_in(xtal_in),
		.pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));
	initial begin
		aclk = 1'h0;
		forever #12.5 aclk = ~aclk;
	end
	task automatic final_report;
		$display("mismatches %0d comparisons %0d", fails, checks);
		if (fails == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, g);
		checks++;
		if (g !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		int k;
		k = 0;
		q.awvalid <= 1'h1;
		q.awaddr <= a;
		q.wvalid <= 1'h1;
		q.wdata <= v;
		q.wstrb <= 4'hF;
		do begin
			@(posedge aclk);
			if (s.awready) q.awvalid <= 1'h0;
			if (s.wready) q.wvalid <= 1'h0;
			k++;
		end while (s.bvalid !== 1'h1 && k < 60);
		rr = s.bresp;
		if (k >= 60) begin
			fails++;
			final_report();
		end
	endtask
	task automatic rd(input logic [7:0] a);
		int k;
		k = 0;
		q.arvalid <= 1'h1;
		q.araddr <= a;
		do begin
			@(posedge aclk);
			if (s.arready) q.arvalid <= 1'h0;
			k++;
		end while (s.rvalid !== 1'h1 && k < 60);
		rv = s.rdata;
		rr = s.rresp;
		if (k >= 60) begin
			fails++;
			final_report();
		end
	endtask
	task automatic tick(input int c);
		repeat (c) begin
			xtal_in <= 1'h1;
			repeat (2) @(posedge aclk);
			xtal_in <= 1'h0;
			repeat (2) @(posedge aclk);
		end
	endtask
	function automatic logic [31:0] bcd(input int v);
		return 32'((v / 10) * 16 + v % 10);
	endfunction
	function automatic int dim(input int m, input int yy);
		if (m == 2) return (yy % 4 == 0) ? 29 : 28;
		return (m == 4 || m == 6 || m == 9 || m == 11) ? 30 : 31;
	endfunction
	initial begin
		aresetn = 1'h0;
		clk_en = 1'h1;
		xtal_in = 1'h0;
		q = '0;
		q.bready = 1'h1;
		q.rready = 1'h1;
		fails = 0;
		checks = 0;
		void'($urandom(32'h55CD48FA));
		repeat (12) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		for (int i = 0; i < 8; i++) begin
			rd(ra[i]);
			chk("reset value", re[i], rv);
		end
		wr(`OFF_HOUR, 32'h15);
		chk("locked write resp", 32'(`RESP_OKAY), 32'(rr));
		rd(`OFF_HOUR);
		chk("locked hour", 0, rv);
		rd(`OFF_IRQ_ST);
		chk("refused status", 32'h4, rv);
		wr(`OFF_IRQ_MASK, 32'h4);
		repeat (2) @(posedge aclk);
		chk("irq raised", 32'h1, 32'(irq));
		wr(`OFF_IRQ_ST, 32'h4);
		repeat (2) @(posedge aclk);
		chk("irq cleared", 0, 32'(irq));
		rd(8'h40);
		chk("unmapped resp", 32'(`RESP_SLVERR), 32'(rr));
		chk("unmapped data", 0, rv);
		clk_en <= 1'h0;
		repeat (3) @(posedge aclk);
		clk_en <= 1'h1;
		wr(`OFF_CTRL, 32'hF);
		for (int c = 0; c < 5; c++) begin
			y = yt[c];
			mo = mt[c];
			d = dt[c];
			wd = wt[c];
			h = 23;
			mi = 59;
			se = 59;
			if (c == 4) begin
				y = $urandom % 100;
				mo = 1 + $urandom % 12;
				d = 1 + $urandom % dim(mo, y);
				wd = $urandom % 7;
				h = $urandom % 24;
				mi = $urandom % 60;
				se = $urandom % 60;
			end
			ex = '{bcd(se), bcd(mi), bcd(h), bcd(wd), bcd(d), bcd(mo), bcd(y)};
			for (int i = 6; i >= 0; i--) wr(ra[i], ex[i]);
			repeat (2) @(posedge aclk);
			chk("pin enable", 32'h1, 32'(pin_oe));
			chk("pin first half", 32'h1, 32'(pin_out));
			rd(`OFF_STAT);
			chk("first half second", 0, rv);
			tick(4);
			rd(`OFF_STAT);
			chk("half second", 32'h1, rv);
			chk("pin second half", 0, 32'(pin_out));
			tick(4);
			se++;
			if (se == 60) begin
				se = 0;
				mi++;
			end
			if (mi == 60) begin
				mi = 0;
				h++;
			end
			if (h == 24) begin
				h = 0;
				wd = (wd + 1) % 7;
				d++;
			end
			if (d > dim(mo, y)) begin
				d = 1;
				mo++;
			end
			if (mo == 13) begin
				mo = 1;
				y = (y + 1) % 100;
			end
			ex = '{bcd(se), bcd(mi), bcd(h), bcd(wd), bcd(d), bcd(mo), bcd(y)};
			for (int i = 0; i < 7; i++) begin
				rd(ra[i]);
				chk("time field", ex[i], rv);
			end
		end
		wr(`OFF_IRQ_MASK, 32'h2);
		wr(`OFF_ALARM, 32'h6);
		wr(`OFF_CTRL, 32'h17);
		wr(`OFF_HOUR, 32'h0);
		wr(`OFF_MIN, 32'h0);
		wr(`OFF_SEC, 32'h5);
		tick(HZ);
		chk("alarm irq", 32'h1, 32'(irq));
		chk("alarm pin", 32'h1, 32'(pin_out));
		rd(`OFF_IRQ_ST);
		chk("alarm status", 32'h3, rv);
		wr(`OFF_IRQ_ST, 32'h3);
		tick(HZ);
		chk("alarm pin end", 0, 32'(pin_out));
		chk("alarm irq end", 0, 32'(irq));
		wr(`OFF_MIN, 32'h59);
		wr(`OFF_SEC, 32'h59);
		wr(`OFF_CTRL, 32'h207);
		tick(HZ);
		rd(`OFF_HOUR);
		chk("hour carry", 32'h1, rv);
		tick(HZ - 2);
		rd(`OFF_SEC);
		chk("short second", 32'h1, rv);
		tick(HZ);
		rd(`OFF_SEC);
		chk("normal second", 32'h2, rv);
		rd(`OFF_MIN);
		chk("minute kept", 32'h0, rv);
		final_report();
	end
endmodule
`default_nettype wire
